// *** rtl/lane_status_defs.svh ***
// register indices, byte addresses, field positions and reset values of the lane status bank
// assumes APB with 32-bit data; byte address is four times the register index
`ifndef LANE_STATUS_DEFS_SVH
`define LANE_STATUS_DEFS_SVH

`define LINK_COUNT 2
`define ADDR_WIDTH 16

`define IDX_LINK_PAGE 12'h300
`define IDX_LANE2_STATUS 12'h4b2
`define IDX_LANE3_STATUS 12'h4b3
`define IDX_ERROR_THRESHOLD 12'h4c0
`define IDX_IRQ_STATUS 12'h4c1
`define IDX_IRQ_CLEAR 12'h4c2
`define IDX_IRQ_ENABLE 12'h4c3

`define ADDR_LINK_PAGE 16'h0c00
`define ADDR_LANE2_STATUS 16'h12c8
`define ADDR_LANE3_STATUS 16'h12cc
`define ADDR_ERROR_THRESHOLD 16'h1300
`define ADDR_IRQ_STATUS 16'h1304
`define ADDR_IRQ_CLEAR 16'h1308
`define ADDR_IRQ_ENABLE 16'h130c

`define BIT_DISPARITY_OVER 7
`define BIT_TABLE_MISS_OVER 6
`define BIT_BAD_CONTROL_CHAR_OVER 5
`define BIT_DESKEW_OK 4
`define BIT_INIT_ALIGN_OK 3
`define BIT_CHECKSUM_OK 2
`define BIT_FRAME_SYNC 1
`define BIT_CODE_GROUP_SYNC 0

`define IRQ_LANE2_SYNC_LOST 0
`define IRQ_LANE2_ERRORS_OVER 1
`define IRQ_LANE3_SYNC_LOST 2
`define IRQ_LANE3_ERRORS_OVER 3
`define IRQ_WIDTH 4

`define RESET_STATUS 8'h00
`define RESET_THRESHOLD 8'hff
`define RESET_PAGE 1'b0

`endif

// *** rtl/lane_status_pkg.sv ***
// types shared by the lane status bank and its per-lane flag unit
// assumes the constants of lane_status_defs.svh
package lane_status_pkg;

	typedef enum logic [1:0]
	{
		APB_IDLE = 2'b00,
		APB_WAIT = 2'b01,
		APB_DONE = 2'b10
	} apb_phase_type;

	typedef struct packed
	{
		logic deskew_ok;
		logic init_align_ok;
		logic checksum_ok;
		logic frame_sync;
		logic code_group_sync;
		logic [7:0] disparity_count;
		logic [7:0] table_miss_count;
		logic [7:0] bad_control_char_count;
	} lane_state_type;

endpackage

// *** rtl/lane_flag_if.sv ***
// carrier between the status bank and one flag unit: lane state in, status byte out
// assumes the lane state is already selected for the current link page
`timescale 1ns/100ps
interface lane_flag_if;
	lane_status_pkg::lane_state_type state;
	logic [7:0] error_threshold;
	logic [7:0] status_byte;

	modport bank
	(
		output state,
		output error_threshold,
		input status_byte
	);

	modport unit
	(
		input state,
		input error_threshold,
		output status_byte
	);
endinterface

// *** rtl/lane_flag_unit.sv ***
// one lane's status byte: sync bits passed through, error counts compared with the threshold
// assumes the bank registers the byte; this unit is purely combinational
`timescale 1ns/100ps
`include "lane_status_defs.svh"
module lane_flag_unit
(
	lane_flag_if.unit lane
);
	always_comb
	begin
		lane.status_byte = 8'h00;
		lane.status_byte[`BIT_DISPARITY_OVER] =
			(lane.state.disparity_count >= lane.error_threshold);
		lane.status_byte[`BIT_TABLE_MISS_OVER] =
			(lane.state.table_miss_count >= lane.error_threshold);
		lane.status_byte[`BIT_BAD_CONTROL_CHAR_OVER] =
			(lane.state.bad_control_char_count >= lane.error_threshold);
		lane.status_byte[`BIT_DESKEW_OK] = lane.state.deskew_ok;
		lane.status_byte[`BIT_INIT_ALIGN_OK] = lane.state.init_align_ok;
		lane.status_byte[`BIT_CHECKSUM_OK] = lane.state.checksum_ok;
		lane.status_byte[`BIT_FRAME_SYNC] = lane.state.frame_sync;
		lane.status_byte[`BIT_CODE_GROUP_SYNC] = lane.state.code_group_sync;
	end
endmodule // lane_flag_unit

// *** rtl/serial_lane_link_status_bank.sv ***
// lane 2 and lane 3 receive status of the serial link, read by software over APB
// assumes deframer state and error counts arrive synchronous to sys_clk_in, one set per link
// How it works
// - lane 2 status bit 4 is 1 when lane 2 inter-lane deskew is achieved, 0 when it failed.
// - lane 2 status bit 3 is 1 while lane 2 initial lane alignment sync holds, 0 when lost.
// - lane 2 status bit 2 is 1 when the lane 2 configuration checksum is correct, else 0.
// - lane 2 status bit 1 is 1 while lane 2 frame sync holds, 0 after it is lost.
// - lane 2 status bit 0 is 1 while lane 2 code group sync holds, 0 when lost.
// - lane 3 status bit 7 is 1 when the disparity error count is at or above the threshold.
// - lane 3 status bit 6 is 1 when the not-in-table count is at or above the threshold.
// - lane 3 status bit 5 is 1 when the unexpected control count is at or above the threshold.
// - lane 3 status bit 4 is 1 when lane 3 is deskewed against the other lanes, 0 on failure.
// - lane 3 status bit 3 is 1 while lane 3 initial lane alignment sync holds, 0 when lost.
// - lane 3 status bit 2 is 1 when the lane 3 configuration checksum is correct, else 0.
// - all status bits show the link chosen by the page selector at index 0x300.
// - lane 2 bits 7, 6, 5 flag the three error counts at or above the threshold.
// - lane 3 bits 1 and 0 show frame sync and code group sync of lane 3.
`timescale 1ns/100ps
`include "lane_status_defs.svh"
module serial_lane_link_status_bank
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`ADDR_WIDTH-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [`LINK_COUNT-1:0] lane2_deskew_ok_in,
	input wire logic [`LINK_COUNT-1:0] lane2_init_align_ok_in,
	input wire logic [`LINK_COUNT-1:0] lane2_checksum_ok_in,
	input wire logic [`LINK_COUNT-1:0] lane2_frame_sync_in,
	input wire logic [`LINK_COUNT-1:0] lane2_code_group_sync_in,
	input wire logic [`LINK_COUNT-1:0][7:0] lane2_disparity_count_in,
	input wire logic [`LINK_COUNT-1:0][7:0] lane2_table_miss_count_in,
	input wire logic [`LINK_COUNT-1:0][7:0] lane2_bad_control_char_count_in,
	input wire logic [`LINK_COUNT-1:0] lane3_deskew_ok_in,
	input wire logic [`LINK_COUNT-1:0] lane3_init_align_ok_in,
	input wire logic [`LINK_COUNT-1:0] lane3_checksum_ok_in,
	input wire logic [`LINK_COUNT-1:0] lane3_frame_sync_in,
	input wire logic [`LINK_COUNT-1:0] lane3_code_group_sync_in,
	input wire logic [`LINK_COUNT-1:0][7:0] lane3_disparity_count_in,
	input wire logic [`LINK_COUNT-1:0][7:0] lane3_table_miss_count_in,
	input wire logic [`LINK_COUNT-1:0][7:0] lane3_bad_control_char_count_in,
	output logic irq_out
);
	lane_status_pkg::apb_phase_type phase_q;
	logic link_page_q;
	logic [7:0] error_threshold_q;
	logic [7:0] lane2_link_status_q;
	logic [7:0] lane3_link_status_q;
	logic page_moved_q;
	logic page_settle_q;
	logic [`IRQ_WIDTH-1:0] irq_status_q;
	logic [`IRQ_WIDTH-1:0] irq_enable_q;
	logic [`IRQ_WIDTH-1:0] irq_event;
	logic [31:0] read_word;
	logic addr_hit;
	logic access_done;
	logic write_done;
	logic lane2_errors_over_q;
	logic lane3_errors_over_q;
	logic lane2_sync_q;
	logic lane3_sync_q;
	logic lane2_errors_over;
	logic lane3_errors_over;
	logic lane2_sync;
	logic lane3_sync;

	lane_flag_if lane2_if();
	lane_flag_if lane3_if();

	// select the paged link's state for each lane
	always_comb
	begin
		lane2_if.state.deskew_ok = lane2_deskew_ok_in[link_page_q];
		lane2_if.state.init_align_ok = lane2_init_align_ok_in[link_page_q];
		lane2_if.state.checksum_ok = lane2_checksum_ok_in[link_page_q];
		lane2_if.state.frame_sync = lane2_frame_sync_in[link_page_q];
		lane2_if.state.code_group_sync = lane2_code_group_sync_in[link_page_q];
		lane2_if.state.disparity_count = lane2_disparity_count_in[link_page_q];
		lane2_if.state.table_miss_count = lane2_table_miss_count_in[link_page_q];
		lane2_if.state.bad_control_char_count = lane2_bad_control_char_count_in[link_page_q];
		lane2_if.error_threshold = error_threshold_q;
		lane3_if.state.deskew_ok = lane3_deskew_ok_in[link_page_q];
		lane3_if.state.init_align_ok = lane3_init_align_ok_in[link_page_q];
		lane3_if.state.checksum_ok = lane3_checksum_ok_in[link_page_q];
		lane3_if.state.frame_sync = lane3_frame_sync_in[link_page_q];
		lane3_if.state.code_group_sync = lane3_code_group_sync_in[link_page_q];
		lane3_if.state.disparity_count = lane3_disparity_count_in[link_page_q];
		lane3_if.state.table_miss_count = lane3_table_miss_count_in[link_page_q];
		lane3_if.state.bad_control_char_count = lane3_bad_control_char_count_in[link_page_q];
		lane3_if.error_threshold = error_threshold_q;
	end

	lane_flag_unit lane2_unit
	(
		.lane(lane2_if.unit)
	);

	lane_flag_unit lane3_unit
	(
		.lane(lane3_if.unit)
	);

	// status bytes follow the deframer every cycle, never written by software
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			lane2_link_status_q <= `RESET_STATUS;
			lane3_link_status_q <= `RESET_STATUS;
		end
		else
		begin
			lane2_link_status_q <= lane2_if.status_byte;
			lane3_link_status_q <= lane3_if.status_byte;
		end
	end

	// apb: one wait state, answer on the second access-phase edge
	assign access_done = psel_in && penable_in && (phase_q == lane_status_pkg::APB_DONE);
	assign write_done = access_done && pwrite_in;

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			phase_q <= lane_status_pkg::APB_IDLE;
		else
		begin
			case (phase_q)
				lane_status_pkg::APB_IDLE:
					if (psel_in && penable_in)
						phase_q <= lane_status_pkg::APB_DONE;
				lane_status_pkg::APB_DONE:
					phase_q <= lane_status_pkg::APB_WAIT;
				lane_status_pkg::APB_WAIT:
					phase_q <= lane_status_pkg::APB_IDLE;
				default:
					phase_q <= lane_status_pkg::APB_IDLE;
			endcase
		end
	end

	// read mux; the clear register reads as zero
	always_comb
	begin
		read_word = 32'h0000_0000;
		addr_hit = 1'b1;
		case (paddr_in)
			`ADDR_LINK_PAGE:
				read_word[0] = link_page_q;
			`ADDR_LANE2_STATUS:
				read_word[7:0] = lane2_link_status_q;
			`ADDR_LANE3_STATUS:
				read_word[7:0] = lane3_link_status_q;
			`ADDR_ERROR_THRESHOLD:
				read_word[7:0] = error_threshold_q;
			`ADDR_IRQ_STATUS:
				read_word[`IRQ_WIDTH-1:0] = irq_status_q;
			`ADDR_IRQ_CLEAR:
				read_word = 32'h0000_0000;
			`ADDR_IRQ_ENABLE:
				read_word[`IRQ_WIDTH-1:0] = irq_enable_q;
			default:
				addr_hit = 1'b0;
		endcase
	end

	// registered answer keeps every bus output straight off a flop
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else if (psel_in && penable_in && (phase_q == lane_status_pkg::APB_IDLE))
		begin
			pready_out <= 1'b1;
			pslverr_out <= !addr_hit;
			prdata_out <= pwrite_in ? 32'h0000_0000 : read_word;
		end
		else
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
	end

	// software-written control, one register each
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			link_page_q <= `RESET_PAGE;
		else if (write_done && (paddr_in == `ADDR_LINK_PAGE) && pstrb_in[0])
			link_page_q <= pwdata_in[0];
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			error_threshold_q <= `RESET_THRESHOLD;
		else if (write_done && (paddr_in == `ADDR_ERROR_THRESHOLD) && pstrb_in[0])
			error_threshold_q <= pwdata_in[7:0];
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			irq_enable_q <= '0;
		else if (write_done && (paddr_in == `ADDR_IRQ_ENABLE) && pstrb_in[0])
			irq_enable_q <= pwdata_in[`IRQ_WIDTH-1:0];
	end

	// events: sync loss and error threshold crossing per lane
	assign lane2_sync = lane2_link_status_q[`BIT_FRAME_SYNC] &&
		lane2_link_status_q[`BIT_CODE_GROUP_SYNC];
	assign lane3_sync = lane3_link_status_q[`BIT_FRAME_SYNC] &&
		lane3_link_status_q[`BIT_CODE_GROUP_SYNC];
	assign lane2_errors_over = |lane2_link_status_q[7:5];
	assign lane3_errors_over = |lane3_link_status_q[7:5];

	// edge history of the shown sync state
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			lane2_sync_q <= 1'b0;
			lane3_sync_q <= 1'b0;
		end
		else
		begin
			lane2_sync_q <= lane2_sync;
			lane3_sync_q <= lane3_sync;
		end
	end

	// edge history of the error flags
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			lane2_errors_over_q <= 1'b0;
			lane3_errors_over_q <= 1'b0;
		end
		else
		begin
			lane2_errors_over_q <= lane2_errors_over;
			lane3_errors_over_q <= lane3_errors_over;
		end
	end

	// a new page reaches the status bytes one cycle late and the history one more
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			page_moved_q <= 1'b0;
			page_settle_q <= 1'b0;
		end
		else
		begin
			page_moved_q <= write_done && (paddr_in == `ADDR_LINK_PAGE);
			page_settle_q <= page_moved_q;
		end
	end

	// a page switch changes the shown link, not the lane; mask until history catches up
	always_comb
	begin
		irq_event = '0;
		if (!page_moved_q && !page_settle_q && !(write_done && (paddr_in == `ADDR_LINK_PAGE)))
		begin
			irq_event[`IRQ_LANE2_SYNC_LOST] = lane2_sync_q && !lane2_sync;
			irq_event[`IRQ_LANE2_ERRORS_OVER] = !lane2_errors_over_q && lane2_errors_over;
			irq_event[`IRQ_LANE3_SYNC_LOST] = lane3_sync_q && !lane3_sync;
			irq_event[`IRQ_LANE3_ERRORS_OVER] = !lane3_errors_over_q && lane3_errors_over;
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			irq_status_q <= '0;
		else if (write_done && (paddr_in == `ADDR_IRQ_CLEAR) && pstrb_in[0])
			irq_status_q <= (irq_status_q & ~pwdata_in[`IRQ_WIDTH-1:0]) | irq_event;
		else
			irq_status_q <= irq_status_q | irq_event;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_status_q & irq_enable_q);
	end
endmodule // serial_lane_link_status_bank

// *** sim/lane_status_monitor.sv ***
// bus and interrupt checks on the lane status bank ports
// assumes a bind from tb; one clock domain
`timescale 1ns/100ps
`include "lane_status_defs.svh"
module lane_status_monitor
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`ADDR_WIDTH-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic irq_out
);
	logic mapped;
	logic [3:0] enable_q;
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	assign mapped = paddr_in inside {`ADDR_LINK_PAGE, `ADDR_LANE2_STATUS, `ADDR_LANE3_STATUS,
		`ADDR_ERROR_THRESHOLD, `ADDR_IRQ_STATUS, `ADDR_IRQ_CLEAR, `ADDR_IRQ_ENABLE};
	// shadow of the enable mask, written where the master samples pready
	always_ff @(posedge sys_clk_in or negedge rstn_in)
		if (!rstn_in)
			enable_q <= 4'h0;
		else if (pready_out && pwrite_in && pstrb_in[0] && paddr_in == `ADDR_IRQ_ENABLE)
			enable_q <= pwdata_in[3:0];
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready held too long");
	a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
		else $error("pready without access");
	a_ready_bound: assert property (psel_in && penable_in && !pready_out |-> ##[1:4] pready_out)
		else $error("pready missing");
	a_err_map: assert property (pready_out |-> pslverr_out == !mapped)
		else $error("wrong error response");
	a_err_clean: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("bad error reply");
	a_data_idle: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data outside reply");
	a_data_narrow: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
		else $error("upper read bits set");
	a_irq_enabled: assert property (irq_out |->
		(enable_q | $past(enable_q) | $past(enable_q, 2)) != 4'h0)
		else $error("irq while masked");
	cover property (pready_out && pslverr_out);
	cover property (pready_out && !pwrite_in && paddr_in == `ADDR_LANE3_STATUS);
	cover property ($rose(irq_out));
endmodule // lane_status_monitor

// *** sim/lane_source_model.sv ***
// far-side source of per-link lane state, refilled from bench random words
// assumes load_in changes just after a rising edge
`timescale 1ns/100ps
module lane_source_model
(
	input wire logic sys_clk_in,
	input wire logic load_in,
	input wire logic [31:0] word_in,
	output lane_status_pkg::lane_state_type [1:0] lane2_out,
	output lane_status_pkg::lane_state_type [1:0] lane3_out
);
	logic [127:0] pool_q;
	// held steady between refills so reads see settled state
	always_ff @(posedge sys_clk_in)
		if (load_in)
			pool_q <= {pool_q[95:0], word_in};
	assign lane2_out = pool_q[57:0];
	assign lane3_out = pool_q[115:58];
endmodule // lane_source_model

// *** sim/tb.sv ***
// self-checking bench: APB master, random lane state per link, verdict
// assumes rtl files and the monitor are compiled first
`timescale 1ns/100ps
`include "lane_status_defs.svh"
module tb;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic load_q = 1'b1;
	logic [15:0] paddr_in = 16'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] lfsr_q = 32'h8964;
	logic [3:0] pstrb_in = 4'hf;
	logic [31:0] prdata_out, rd;
	logic pready_out, pslverr_out, irq_out, err, page;
	logic [7:0] thr;
	logic [3:0] eirq;
	logic [31:0] e2, e3;
	int num_errors = 0;
	int check_count = 0;
	lane_status_pkg::lane_state_type [1:0] s2, s3;
	always #5 sys_clk_in = ~sys_clk_in;
	lane_source_model src (.sys_clk_in(sys_clk_in), .load_in(load_q), .word_in(lfsr_q),
		.lane2_out(s2), .lane3_out(s3));
	serial_lane_link_status_bank dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
		.lane2_deskew_ok_in({s2[1].deskew_ok, s2[0].deskew_ok}),
		.lane2_init_align_ok_in({s2[1].init_align_ok, s2[0].init_align_ok}),
		.lane2_checksum_ok_in({s2[1].checksum_ok, s2[0].checksum_ok}),
		.lane2_frame_sync_in({s2[1].frame_sync, s2[0].frame_sync}),
		.lane2_code_group_sync_in({s2[1].code_group_sync, s2[0].code_group_sync}),
		.lane2_disparity_count_in({s2[1].disparity_count, s2[0].disparity_count}),
		.lane2_table_miss_count_in({s2[1].table_miss_count, s2[0].table_miss_count}),
		.lane2_bad_control_char_count_in({s2[1].bad_control_char_count,
			s2[0].bad_control_char_count}),
		.lane3_deskew_ok_in({s3[1].deskew_ok, s3[0].deskew_ok}),
		.lane3_init_align_ok_in({s3[1].init_align_ok, s3[0].init_align_ok}),
		.lane3_checksum_ok_in({s3[1].checksum_ok, s3[0].checksum_ok}),
		.lane3_frame_sync_in({s3[1].frame_sync, s3[0].frame_sync}),
		.lane3_code_group_sync_in({s3[1].code_group_sync, s3[0].code_group_sync}),
		.lane3_disparity_count_in({s3[1].disparity_count, s3[0].disparity_count}),
		.lane3_table_miss_count_in({s3[1].table_miss_count, s3[0].table_miss_count}),
		.lane3_bad_control_char_count_in({s3[1].bad_control_char_count,
			s3[0].bad_control_char_count}));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] exp_byte(lane_status_pkg::lane_state_type s, logic [7:0] t);
		return {24'h0, s.disparity_count >= t, s.table_miss_count >= t,
			s.bad_control_char_count >= t, s.deskew_ok, s.init_align_ok, s.checksum_ok,
			s.frame_sync, s.code_group_sync};
	endfunction
	// any count already at the reset threshold, so its flag cannot rise again
	function automatic logic ff_hit(lane_status_pkg::lane_state_type s);
		return (s.disparity_count == 8'hff) || (s.table_miss_count == 8'hff) ||
			(s.bad_control_char_count == 8'hff);
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic fail(string m);
		num_errors++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask
	task automatic chk_word(logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp)
			fail($sformatf("word %h expected %h", got, exp));
	endtask
	task automatic chk_flag(logic got, logic exp);
		check_count++;
		if (got !== exp)
			fail($sformatf("flag %b expected %b", got, exp));
	endtask
	task automatic step();
		@(posedge sys_clk_in);
		lfsr_q <= lfsr(lfsr_q);
	endtask
	task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
		int n = 0;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 20);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n >= 20)
		begin
			fail("no pready");
			stop_test();
		end
	endtask
	task automatic rd_chk(logic [15:0] a, logic [31:0] exp, logic experr);
		apb(1'b0, a, 32'h0);
		chk_word(rd, exp);
		chk_flag(err, experr);
	endtask
	initial
	begin
		repeat (5) step();
		rstn_in <= 1'b1;
		load_q <= 1'b0;
		rd_chk(`ADDR_ERROR_THRESHOLD, 32'hff, 1'b0);
		rd_chk(`ADDR_IRQ_ENABLE, 32'h0, 1'b0);
		rd_chk(`ADDR_IRQ_STATUS, {28'h0, ff_hit(s3[0]), 1'b0, ff_hit(s2[0]), 1'b0}, 1'b0);
		$display("reset values done");
		for (int i = 0; i < 24; i++)
		begin
			load_q <= 1'b1;
			repeat (4) step();
			load_q <= 1'b0;
			step();
			page = lfsr_q[31];
			// boundary cases: threshold equal to a count, and zero
			thr = (i % 3 == 0) ? s3[page].disparity_count : (i % 3 == 1) ? 8'h00 : lfsr_q[7:0];
			apb(1'b1, `ADDR_LINK_PAGE, {31'h0, page});
			apb(1'b1, `ADDR_ERROR_THRESHOLD, {24'h0, thr});
			repeat (3) step();
			e2 = exp_byte(s2[page], thr);
			e3 = exp_byte(s3[page], thr);
			rd_chk(`ADDR_LANE2_STATUS, e2, 1'b0);
			rd_chk(`ADDR_LANE3_STATUS, e3, 1'b0);
		end
		apb(1'b1, `ADDR_LANE3_STATUS, 32'hff);
		rd_chk(`ADDR_LANE3_STATUS, exp_byte(s3[page], thr), 1'b0);
		rd_chk(16'h1310, 32'h0, 1'b1);
		rd_chk(`ADDR_IRQ_CLEAR, 32'h0, 1'b0);
		$display("random reads done");
		apb(1'b1, `ADDR_ERROR_THRESHOLD, 32'hff);
		apb(1'b1, `ADDR_IRQ_ENABLE, 32'hf);
		apb(1'b1, `ADDR_IRQ_CLEAR, 32'hf);
		repeat (3) step();
		rd_chk(`ADDR_IRQ_STATUS, 32'h0, 1'b0);
		chk_flag(irq_out, 1'b0);
		// threshold zero raises every error flag not already at 0xff
		eirq = {!ff_hit(s3[page]), 1'b0, !ff_hit(s2[page]), 1'b0};
		apb(1'b1, `ADDR_ERROR_THRESHOLD, 32'h0);
		repeat (4) step();
		rd_chk(`ADDR_IRQ_STATUS, {28'h0, eirq}, 1'b0);
		chk_flag(irq_out, |eirq);
		apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0);
		repeat (3) step();
		chk_flag(irq_out, 1'b0);
		apb(1'b1, `ADDR_IRQ_ENABLE, 32'h8);
		repeat (3) step();
		chk_flag(irq_out, eirq[3]);
		apb(1'b1, `ADDR_IRQ_CLEAR, 32'ha);
		repeat (3) step();
		chk_flag(irq_out, 1'b0);
		rd_chk(`ADDR_IRQ_STATUS, 32'h0, 1'b0);
		// a page switch alone must not raise an event
		apb(1'b1, `ADDR_LINK_PAGE, {31'h0, !page});
		repeat (4) step();
		rd_chk(`ADDR_IRQ_STATUS, 32'h0, 1'b0);
		$display("interrupt done");
		stop_test();
	end
endmodule // tb
bind serial_lane_link_status_bank lane_status_monitor mon (.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out));
